// [logic/fsc_cpl_if.sv]
// Interface between the command controller and the completion pin driver.
`timescale 1ns/1ps
interface fsc_cpl_if;
  logic [1:0] mode;
  logic       busy;
  logic       erase_done;
  logic       prog_done;

  modport ctl (output mode, output busy, output erase_done, output prog_done);
  modport pin (input mode, input busy, input erase_done, input prog_done);
endinterface : fsc_cpl_if

// [logic/fsc_cpl_pin.sv]
// Completion output pin driver: level or low-going pulse, open drain.
`timescale 1ns/1ps
module fsc_cpl_pin #(
  parameter int PULSE_CYCLES = fsc_pkg::PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // Controller side
  fsc_cpl_if.pin    cpl,
  // Open-drain pin
  output logic      pin_out_o,
  output logic      pin_oe_o
);

  localparam int CNT_W = $clog2(PULSE_CYCLES + 1);

  generate
    if (PULSE_CYCLES < 1) begin : g_bad
      $error("PULSE_CYCLES must be at least one");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             oe_ff;
  logic             nxt_oe;
  logic             fire;

  always_comb begin
    fire = 1'b0;
    case (cpl.mode)
      fsc_pkg::CFG_ERASE: fire = cpl.erase_done; // R8
      fsc_pkg::CFG_PROG:  fire = cpl.prog_done;  // R9
      fsc_pkg::CFG_BOTH:  fire = cpl.erase_done | cpl.prog_done; // R10
      default:            fire = 1'b0;
    endcase
    nxt_cnt = cnt_ff;
    if (fire) begin
      nxt_cnt = CNT_W'(PULSE_CYCLES); // R11 R17
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
    // Level mode pulls the pin low while busy; pulse modes pull low while counting.
    if (cpl.mode == fsc_pkg::CFG_LEVEL) begin
      nxt_oe = cpl.busy; // R5 R7
    end else begin
      nxt_oe = (nxt_cnt != '0); // R11
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      oe_ff  <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      oe_ff  <= nxt_oe;
    end
  end

  assign pin_oe_o  = oe_ff;
  // The pin is only ever pulled low, so its driven level is a constant zero.
  assign pin_out_o = 1'b0;

endmodule : fsc_cpl_pin

// [logic/fsc_ctrl.sv]
// Command interpreter with completion pin configuration over Avalon-MM.
//
// Behaviour
// R1 - Query data only via single-word reads
// R2 - Command selects completion pin level or pulse
// R3 - Selected mode persists until reset or reconfigure
// R4 - Level mode after reset by default
// R5 - Level mode shows write controller busy
// R6 - Host configures only when idle
// R7 - Code 00 selects level ready indication
// R8 - Code 01 pulses on erase complete
// R9 - Code 10 pulses on program complete
// R10 - Code 11 pulses on either complete
// R11 - Pulse modes drive low pulse near 250ns
// R12 - Invalid code sets program and erase error
// R13 - Bad lock second cycle gives sequence error
// R14 - Status on low byte, upper byte zero
// R15 - Both errors with ready mean sequence error
// R16 - Error bits cleared only by clear or reset
// R17 - Pulse width is fixed clock count
// R18 - Sequence error keeps config, reads status
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module fsc_ctrl #(
  parameter int PROG_CYCLES  = 100,
  parameter int ERASE_CYCLES = 400,
  parameter int PULSE_CYCLES = fsc_pkg::PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Completion output pin, open drain
  output logic             cpl_pin_out_o,
  output logic             cpl_pin_oe_o,
  // Interrupt
  output logic             irq_o
);

  localparam int OP_W = 16;

  generate
    if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << OP_W) ||
        ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << OP_W)) begin : g_bad
      $error("PROG_CYCLES and ERASE_CYCLES must fit the operation counter");
    end
  endgenerate

  // Bus handshake: one wait cycle per request, then the answer.
  logic        wait_ff;
  logic        nxt_wait;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        req;
  logic        accept;
  logic        cmd_wr;
  logic [7:0]  cmd;

  assign req    = avs_read_i | avs_write_i;
  assign accept = req & ~wait_ff;
  assign cmd_wr = accept & avs_write_i & (avs_address_i == fsc_pkg::REG_CMD);
  assign cmd    = avs_writedata_i[7:0];

  // Controller state.
  fsc_pkg::fsc_state_e state_ff;
  fsc_pkg::fsc_state_e nxt_state;
  logic [1:0]          mode_ff;
  logic [1:0]          nxt_mode;
  logic                ee_ff;
  logic                nxt_ee;
  logic                pe_ff;
  logic                nxt_pe;
  logic [OP_W-1:0]     op_cnt_ff;
  logic [OP_W-1:0]     nxt_op_cnt;
  logic                erase_done_ff;
  logic                nxt_erase_done;
  logic                prog_done_ff;
  logic                nxt_prog_done;
  logic                seq_err;
  logic                busy;
  logic [7:0]          status;

  assign busy = (state_ff == fsc_pkg::ST_PROG_BUSY) | (state_ff == fsc_pkg::ST_ERASE_BUSY);

  always_comb begin
    status                        = 8'h00;
    status[fsc_pkg::SR_READY]     = ~busy;
    status[fsc_pkg::SR_ERASE_ERR] = ee_ff; // R15
    status[fsc_pkg::SR_PROG_ERR]  = pe_ff; // R15
  end

  always_comb begin
    nxt_state      = state_ff;
    nxt_mode       = mode_ff;
    nxt_ee         = ee_ff;
    nxt_pe         = pe_ff;
    nxt_op_cnt     = op_cnt_ff;
    nxt_erase_done = 1'b0;
    nxt_prog_done  = 1'b0;
    seq_err        = 1'b0;
    case (state_ff)
      fsc_pkg::ST_PROG_SETUP: begin
        if (cmd_wr) begin
          nxt_state  = fsc_pkg::ST_PROG_BUSY;
          nxt_op_cnt = OP_W'(PROG_CYCLES);
        end
      end
      fsc_pkg::ST_ERASE_SETUP: begin
        if (cmd_wr && cmd == fsc_pkg::CMD_CONFIRM) begin
          nxt_state  = fsc_pkg::ST_ERASE_BUSY;
          nxt_op_cnt = OP_W'(ERASE_CYCLES);
        end else if (cmd_wr) begin
          seq_err = 1'b1;
        end
      end
      fsc_pkg::ST_LOCK_SETUP: begin
        if (cmd_wr) begin
          if (cmd == fsc_pkg::CMD_CONFIRM || cmd == fsc_pkg::LOCK_OK_A ||
              cmd == fsc_pkg::LOCK_OK_B || cmd == fsc_pkg::LOCK_OK_C) begin
            nxt_state = fsc_pkg::ST_READ_STATUS;
          end else begin
            seq_err = 1'b1; // R13
          end
        end
      end
      fsc_pkg::ST_CFG_SETUP: begin
        if (cmd_wr) begin
          nxt_state = fsc_pkg::ST_READ_STATUS;
          if (cmd[7:2] == fsc_pkg::CFG_RSVD_ZERO) begin
            nxt_mode = cmd[1:0]; // R2 R3
          end else begin
            nxt_ee = 1'b1; // R12
            nxt_pe = 1'b1; // R12
          end
        end
      end
      fsc_pkg::ST_PROG_BUSY, fsc_pkg::ST_ERASE_BUSY: begin
        // Commands are ignored while busy; suspend is not supported here.
        if (op_cnt_ff > OP_W'(1)) begin
          nxt_op_cnt = op_cnt_ff - 1'b1;
        end else begin
          nxt_op_cnt     = '0;
          nxt_state      = fsc_pkg::ST_READ_STATUS;
          nxt_prog_done  = (state_ff == fsc_pkg::ST_PROG_BUSY);
          nxt_erase_done = (state_ff == fsc_pkg::ST_ERASE_BUSY);
        end
      end
      default: begin
        if (cmd_wr) begin
          case (cmd)
            fsc_pkg::CMD_READ_ARRAY:  nxt_state = fsc_pkg::ST_READ_ARRAY;
            fsc_pkg::CMD_READ_STATUS: nxt_state = fsc_pkg::ST_READ_STATUS;
            fsc_pkg::CMD_READ_CONFIG: nxt_state = fsc_pkg::ST_READ_CONFIG;
            fsc_pkg::CMD_READ_QUERY:  nxt_state = fsc_pkg::ST_READ_QUERY;
            fsc_pkg::CMD_PROG_A,
            fsc_pkg::CMD_PROG_B:      nxt_state = fsc_pkg::ST_PROG_SETUP;
            fsc_pkg::CMD_ERASE:       nxt_state = fsc_pkg::ST_ERASE_SETUP;
            fsc_pkg::CMD_LOCK_SETUP:  nxt_state = fsc_pkg::ST_LOCK_SETUP;
            fsc_pkg::CMD_CPL_CONFIG:  nxt_state = fsc_pkg::ST_CFG_SETUP; // R6
            fsc_pkg::CMD_CLEAR_SR: begin
              nxt_ee = 1'b0; // R16
              nxt_pe = 1'b0; // R16
            end
            default:                  nxt_state = state_ff;
          endcase
        end
      end
    endcase
    if (seq_err) begin
      // Mode is left as it was; only the state and the error flags move.
      nxt_state = fsc_pkg::ST_SEQ_ERROR; // R18
      nxt_ee    = 1'b1; // R15
      nxt_pe    = 1'b1; // R15
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_ff      <= fsc_pkg::ST_READ_ARRAY;
      mode_ff       <= fsc_pkg::CFG_LEVEL; // R4
      ee_ff         <= fsc_pkg::SR_RESET[fsc_pkg::SR_ERASE_ERR];
      pe_ff         <= fsc_pkg::SR_RESET[fsc_pkg::SR_PROG_ERR];
      op_cnt_ff     <= '0;
      erase_done_ff <= 1'b0;
      prog_done_ff  <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      mode_ff       <= nxt_mode;
      ee_ff         <= nxt_ee;
      pe_ff         <= nxt_pe;
      op_cnt_ff     <= nxt_op_cnt;
      erase_done_ff <= nxt_erase_done;
      prog_done_ff  <= nxt_prog_done;
    end
  end

  // Query store: address register and the word it selects.
  logic [7:0]  qaddr_ff;
  logic [7:0]  nxt_qaddr;
  logic [15:0] qword;

  always_comb begin
    if (qaddr_ff == fsc_pkg::QRY_BASE) begin
      qword = {8'h00, fsc_pkg::QRY_Q};
    end else if (qaddr_ff == fsc_pkg::QRY_BASE + 8'h01) begin
      qword = {8'h00, fsc_pkg::QRY_R};
    end else if (qaddr_ff == fsc_pkg::QRY_BASE + 8'h02) begin
      qword = {8'h00, fsc_pkg::QRY_Y};
    end else begin
      qword = 16'h0000;
    end
  end

  // Interrupt status and mask.
  localparam int IRQ_WL = fsc_pkg::IRQ_W;
  logic [IRQ_WL-1:0] irq_stat_ff;
  logic [IRQ_WL-1:0] nxt_irq_stat;
  logic [IRQ_WL-1:0] irq_mask_ff;
  logic [IRQ_WL-1:0] nxt_irq_mask;
  logic [IRQ_WL-1:0] irq_ev;
  logic              irq_ff;
  logic              nxt_irq;

  always_comb begin
    irq_ev                          = '0;
    irq_ev[fsc_pkg::IRQ_ERASE_DONE] = erase_done_ff;
    irq_ev[fsc_pkg::IRQ_PROG_DONE]  = prog_done_ff;
    irq_ev[fsc_pkg::IRQ_SEQ_ERR]    = seq_err;
    nxt_irq_stat = irq_stat_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_qaddr    = qaddr_ff;
    if (accept && avs_write_i) begin
      if (avs_address_i == fsc_pkg::REG_QADDR) begin
        nxt_qaddr = avs_writedata_i[7:0];
      end else if (avs_address_i == fsc_pkg::REG_IRQ_STAT) begin
        nxt_irq_stat = irq_stat_ff & ~avs_writedata_i[IRQ_WL-1:0];
      end else if (avs_address_i == fsc_pkg::REG_IRQ_MASK) begin
        nxt_irq_mask = avs_writedata_i[IRQ_WL-1:0];
      end
    end
    // A new event wins over a clear in the same cycle.
    nxt_irq_stat = nxt_irq_stat | irq_ev;
    nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);
  end

  // Read mux; Avalon has no burst here, so every read is a single word.
  always_comb begin
    nxt_wait  = ~(req & wait_ff);
    nxt_rdata = rdata_ff;
    if (avs_read_i && wait_ff) begin
      if (avs_address_i == fsc_pkg::REG_CMD) begin
        case (state_ff)
          fsc_pkg::ST_READ_ARRAY:  nxt_rdata = 32'h0000_0000;
          fsc_pkg::ST_READ_CONFIG: nxt_rdata = {30'h0000_0000, mode_ff};
          fsc_pkg::ST_READ_QUERY:  nxt_rdata = {16'h0000, qword}; // R1
          default:                 nxt_rdata = {24'h00_0000, status}; // R14 R18
        endcase
      end else if (avs_address_i == fsc_pkg::REG_QADDR) begin
        nxt_rdata = {24'h00_0000, qaddr_ff};
      end else if (avs_address_i == fsc_pkg::REG_IRQ_STAT) begin
        nxt_rdata = {29'h0000_0000, irq_stat_ff};
      end else if (avs_address_i == fsc_pkg::REG_IRQ_MASK) begin
        nxt_rdata = {29'h0000_0000, irq_mask_ff};
      end else if (avs_address_i == fsc_pkg::REG_INFO) begin
        nxt_rdata = {24'h00_0000, state_ff, busy, 1'b0, mode_ff};
      end else begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wait_ff     <= 1'b1;
      rdata_ff    <= 32'h0000_0000;
      qaddr_ff    <= 8'h00;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff      <= 1'b0;
    end else begin
      wait_ff     <= nxt_wait;
      rdata_ff    <= nxt_rdata;
      qaddr_ff    <= nxt_qaddr;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff      <= nxt_irq;
    end
  end

  assign avs_waitrequest_o = wait_ff;
  assign avs_readdata_o    = rdata_ff;
  assign irq_o             = irq_ff;

  // Completion pin driver.
  fsc_cpl_if cpl ();

  assign cpl.mode       = mode_ff;
  assign cpl.busy       = busy;
  assign cpl.erase_done = erase_done_ff;
  assign cpl.prog_done  = prog_done_ff;

  fsc_cpl_pin #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_pin (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .cpl       (cpl.pin),
    .pin_out_o (cpl_pin_out_o),
    .pin_oe_o  (cpl_pin_oe_o)
  );

endmodule : fsc_ctrl

// [logic/fsc_pkg.sv]
// Shared constants and types for the flash status-pin command controller.
package fsc_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] REG_CMD      = 5'h00;
  localparam logic [4:0] REG_QADDR    = 5'h04;
  localparam logic [4:0] REG_IRQ_STAT = 5'h08;
  localparam logic [4:0] REG_IRQ_MASK = 5'h0c;
  localparam logic [4:0] REG_INFO     = 5'h10;

  // Command bytes.
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_CONFIG = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY  = 8'h98;
  localparam logic [7:0] CMD_CLEAR_SR    = 8'h50;
  localparam logic [7:0] CMD_PROG_A      = 8'h40;
  localparam logic [7:0] CMD_PROG_B      = 8'h10;
  localparam logic [7:0] CMD_ERASE       = 8'h20;
  localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
  localparam logic [7:0] CMD_LOCK_SETUP  = 8'h60;
  localparam logic [7:0] CMD_CPL_CONFIG  = 8'hb8;
  localparam logic [7:0] LOCK_OK_A       = 8'h01;
  localparam logic [7:0] LOCK_OK_B       = 8'h2f;
  localparam logic [7:0] LOCK_OK_C       = 8'h03;

  // Status byte layout and reset value.
  localparam int         SR_READY      = 7;
  localparam int         SR_ERASE_ERR  = 5;
  localparam int         SR_PROG_ERR   = 4;
  localparam logic [7:0] SR_RESET      = 8'h80;

  // Completion pin configuration codes.
  localparam logic [1:0] CFG_LEVEL     = 2'h0;
  localparam logic [1:0] CFG_ERASE     = 2'h1;
  localparam logic [1:0] CFG_PROG      = 2'h2;
  localparam logic [1:0] CFG_BOTH      = 2'h3;
  localparam logic [5:0] CFG_RSVD_ZERO = 6'h00;

  // Interrupt status bits.
  localparam int IRQ_ERASE_DONE = 0;
  localparam int IRQ_PROG_DONE  = 1;
  localparam int IRQ_SEQ_ERR    = 2;
  localparam int IRQ_W          = 3;

  // Query words: the identifying string at its start offset.
  localparam logic [7:0] QRY_BASE = 8'h10;
  localparam logic [7:0] QRY_Q    = 8'h51;
  localparam logic [7:0] QRY_R    = 8'h52;
  localparam logic [7:0] QRY_Y    = 8'h59;

  // Pulse timing; the typical width is rounded up to whole clocks.
  localparam int CLK_PERIOD_NS = 40;
  localparam int PULSE_NS      = 250;
  localparam int PULSE_CYCLES  = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_READ_ARRAY,
    ST_READ_STATUS,
    ST_READ_CONFIG,
    ST_READ_QUERY,
    ST_PROG_SETUP,
    ST_PROG_BUSY,
    ST_ERASE_SETUP,
    ST_ERASE_BUSY,
    ST_LOCK_SETUP,
    ST_CFG_SETUP,
    ST_SEQ_ERROR
  } fsc_state_e;

endpackage : fsc_pkg

// [sim/flash_status_pin_command_control_bench.sv]
// Self-checking bench for the status-pin command controller.
`timescale 1ns/1ps
module flash_status_pin_command_control_bench;
  typedef struct {logic [1:0] code; int prog_p; int all_p; int lows;} fsc_row_s;
  fsc_row_s    rows [4] = '{'{2'h0, 0, 0, 2}, '{2'h1, 0, 1, 1}, '{2'h2, 1, 1, 1}, '{2'h3, 1, 2, 2}};
  logic [7:0]  lock_ok [4] = '{fsc_pkg::CMD_CONFIRM, fsc_pkg::LOCK_OK_A,
                               fsc_pkg::LOCK_OK_B, fsc_pkg::LOCK_OK_C};
  logic [7:0]  qry [4] = '{fsc_pkg::QRY_Q, fsc_pkg::QRY_R, fsc_pkg::QRY_Y, 8'h00};
  logic        ref_clk_i;
  logic        rst_i;
  logic [4:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        cpl_pin_out_o;
  logic        cpl_pin_oe_o;
  logic        irq_o;
  logic        line;
  int          lows;
  int          pulses;
  int          errors = 0;
  int          num_checks = 0;
  int          p0;
  int          l0;

  fsc_ctrl #(.PROG_CYCLES(3), .ERASE_CYCLES(5)) DUT (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .cpl_pin_out_o(cpl_pin_out_o), .cpl_pin_oe_o(cpl_pin_oe_o), .irq_o(irq_o));
  fsc_host_line u_host (.ref_clk_i(ref_clk_i), .pin_out_i(cpl_pin_out_o),
    .pin_oe_i(cpl_pin_oe_o), .line_o(line), .lows_o(lows), .pulses_o(pulses));

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One access; the request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_read_i      <= !wr;
    avs_write_i     <= wr;
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      n++;
      if (n > 20) begin
        errors++;
        complete_run();
      end
      @(posedge ref_clk_i);
    end
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, q, exp);
  endtask : rd_chk

  // Starts an operation and polls status until ready, then lets the pulse finish.
  task automatic run_op(input logic [7:0] c);
    logic [31:0] q;
    int n;
    wr(fsc_pkg::REG_CMD, {24'h0, c});
    wr(fsc_pkg::REG_CMD, c == fsc_pkg::CMD_ERASE ? 32'hd0 : 32'h5a);
    n = 0;
    q = 32'h0;
    while (q[7] !== 1'b1) begin
      n++;
      if (n > 30) begin
        errors++;
        complete_run();
      end
      bus(1'b0, fsc_pkg::REG_CMD, 32'h0, q);
    end
    repeat (12) @(posedge ref_clk_i);
  endtask : run_op

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    rst_i = 1'b1;
    avs_address_i = 5'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd_chk("info", fsc_pkg::REG_INFO, 32'h0);
    wr(fsc_pkg::REG_IRQ_MASK, 32'h0);
    foreach (rows[i]) begin
      p0 = pulses;
      l0 = lows;
      // Configuration is only issued while the device is idle.
      wr(fsc_pkg::REG_CMD, 32'hb8);
      wr(fsc_pkg::REG_CMD, {30'h0, rows[i].code});
      rd_chk("info", fsc_pkg::REG_INFO, {24'h0, 6'h04, rows[i].code});
      rd_chk("status", fsc_pkg::REG_CMD, 32'h80);
      run_op(fsc_pkg::CMD_PROG_A);
      chk("prog pulses", pulses - p0, rows[i].prog_p);
      run_op(fsc_pkg::CMD_ERASE);
      chk("all pulses", pulses - p0, rows[i].all_p);
      chk("lows", lows - l0, rows[i].lows);
      rd_chk("irq stat", fsc_pkg::REG_IRQ_STAT, 32'h3);
      chk("irq masked", irq_o, 1'b0);
      wr(fsc_pkg::REG_IRQ_STAT, 32'h7);
    end
    wr(fsc_pkg::REG_IRQ_MASK, 32'h7);
    run_op(fsc_pkg::CMD_PROG_B);
    chk("irq set", irq_o, 1'b1);
    wr(fsc_pkg::REG_IRQ_STAT, 32'h2);
    @(posedge ref_clk_i);
    chk("irq clear", irq_o, 1'b0);
    wr(fsc_pkg::REG_CMD, 32'hb8);
    wr(fsc_pkg::REG_CMD, 32'h04);
    rd_chk("bad code", fsc_pkg::REG_CMD, 32'hb0);
    rd_chk("mode kept", fsc_pkg::REG_INFO, 32'h13);
    wr(fsc_pkg::REG_CMD, {24'h0, fsc_pkg::CMD_READ_CONFIG});
    rd_chk("config", fsc_pkg::REG_CMD, {30'h0, fsc_pkg::CFG_BOTH});
    wr(fsc_pkg::REG_CMD, 32'h70);
    rd_chk("sticky", fsc_pkg::REG_CMD, 32'hb0);
    wr(fsc_pkg::REG_CMD, 32'h50);
    rd_chk("cleared", fsc_pkg::REG_CMD, 32'h80);
    wr(fsc_pkg::REG_IRQ_STAT, 32'h7);
    wr(fsc_pkg::REG_CMD, 32'h60);
    wr(fsc_pkg::REG_CMD, 32'h55);
    rd_chk("lock bad", fsc_pkg::REG_CMD, 32'hb0);
    rd_chk("seq irq", fsc_pkg::REG_IRQ_STAT, 32'h4);
    rd_chk("seq info", fsc_pkg::REG_INFO, 32'ha3);
    wr(fsc_pkg::REG_CMD, 32'h50);
    // A bad confirm after erase setup is a sequence error as well.
    wr(fsc_pkg::REG_CMD, {24'h0, fsc_pkg::CMD_ERASE});
    wr(fsc_pkg::REG_CMD, 32'h55);
    rd_chk("erase bad", fsc_pkg::REG_CMD, 32'hb0);
    wr(fsc_pkg::REG_CMD, 32'h50);
    foreach (lock_ok[i]) begin
      wr(fsc_pkg::REG_CMD, 32'h60);
      wr(fsc_pkg::REG_CMD, {24'h0, lock_ok[i]});
      rd_chk("lock ok", fsc_pkg::REG_CMD, 32'h80);
    end
    wr(fsc_pkg::REG_CMD, 32'h98);
    foreach (qry[i]) begin
      wr(fsc_pkg::REG_QADDR, 32'h10 + i);
      rd_chk("query", fsc_pkg::REG_CMD, {24'h0, qry[i]});
    end
    wr(fsc_pkg::REG_CMD, {24'h0, fsc_pkg::CMD_READ_ARRAY});
    rd_chk("array", fsc_pkg::REG_CMD, 32'h0);
    rd_chk("unmapped", 5'h14, 32'h0);
    wr(fsc_pkg::REG_CMD, 32'h40);
    wr(fsc_pkg::REG_CMD, 32'h5a);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    chk("pin idle", cpl_pin_oe_o, 1'b0);
    rd_chk("mode reset", fsc_pkg::REG_INFO, 32'h0);
    complete_run();
  end
endmodule : flash_status_pin_command_control_bench

// [sim/fsc_ctrl_assertions.sv]
// Port-level checker for the status-pin command controller.
`timescale 1ns/1ps
module fsc_ctrl_assertions (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Pin and interrupt
  input wire logic        cpl_pin_out_o,
  input wire logic        cpl_pin_oe_o,
  input wire logic        irq_o
);
  logic       cfg_wait_ff;
  logic       nxt_cfg_wait;
  logic [1:0] mode_ff;
  logic [1:0] nxt_mode;
  logic       cmd_wr;

  // The pin mode is shadowed from accepted command writes.
  assign cmd_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == fsc_pkg::REG_CMD;
  always_comb begin
    nxt_cfg_wait = cfg_wait_ff;
    nxt_mode     = mode_ff;
    if (cmd_wr) begin
      nxt_cfg_wait = !cfg_wait_ff && avs_writedata_i[7:0] == fsc_pkg::CMD_CPL_CONFIG;
      if (cfg_wait_ff && avs_writedata_i[7:2] == fsc_pkg::CFG_RSVD_ZERO) begin
        nxt_mode = avs_writedata_i[1:0];
      end
    end
  end
  always_ff @(posedge ref_clk_i) begin
    cfg_wait_ff <= rst_i ? 1'b0 : nxt_cfg_wait;
    mode_ff     <= rst_i ? fsc_pkg::CFG_LEVEL : nxt_mode;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_wait_answer;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("request not answered");
  property p_wait_short;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_short: assert property (p_wait_short) else $error("answer held too long");
  property p_rdata_hold;
    !$stable(avs_readdata_o) |-> $past(avs_read_i);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_open_drain;
    cpl_pin_out_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  property p_pulse_width;
    $rose(cpl_pin_oe_o) && mode_ff != fsc_pkg::CFG_LEVEL |-> cpl_pin_oe_o [*7] ##1 !cpl_pin_oe_o;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
  property p_level_busy;
    $rose(cpl_pin_oe_o) && mode_ff == fsc_pkg::CFG_LEVEL |-> cpl_pin_oe_o [*3];
  endproperty
  a_level_busy: assert property (p_level_busy) else $error("level low too short");
  property p_after_reset;
    $fell(rst_i) |-> !cpl_pin_oe_o && !irq_o && avs_waitrequest_o && avs_readdata_o == 32'h0;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("outputs active after reset");
  property p_upper_zero;
    avs_read_i && !avs_waitrequest_o && avs_address_i == fsc_pkg::REG_CMD
      |=> avs_readdata_o[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper data not zero");

  c_pulse: cover property ($rose(cpl_pin_oe_o) && mode_ff == fsc_pkg::CFG_BOTH);
  c_level: cover property ($rose(cpl_pin_oe_o) && mode_ff == fsc_pkg::CFG_LEVEL);
  c_irq:   cover property ($rose(irq_o));
endmodule : fsc_ctrl_assertions

bind fsc_ctrl fsc_ctrl_assertions u_chk (
  .ref_clk_i        (ref_clk_i),
  .rst_i            (rst_i),
  .avs_address_i    (avs_address_i),
  .avs_read_i       (avs_read_i),
  .avs_write_i      (avs_write_i),
  .avs_writedata_i  (avs_writedata_i),
  .avs_readdata_o   (avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .cpl_pin_out_o    (cpl_pin_out_o),
  .cpl_pin_oe_o     (cpl_pin_oe_o),
  .irq_o            (irq_o)
);

// [sim/fsc_host_line.sv]
// Host side of the open-drain completion line: pull-up and low-interval counters.
`timescale 1ns/1ps
module fsc_host_line #(
  parameter int PULSE_W = fsc_pkg::PULSE_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic pin_out_i,
  input  wire logic pin_oe_i,
  output logic      line_o,
  output int        lows_o,
  output int        pulses_o
);
  int width;

  // A pull-up holds the line high whenever the device lets go.
  assign line_o = pin_oe_i ? pin_out_i : 1'b1;
  initial begin
    lows_o   = 0;
    pulses_o = 0;
    width    = 0;
  end
  always @(posedge ref_clk_i) begin
    if (!line_o) begin
      width <= width + 1;
    end else if (width != 0) begin
      lows_o <= lows_o + 1;
      if (width == PULSE_W) begin
        pulses_o <= pulses_o + 1;
      end
      width <= 0;
    end
  end
endmodule : fsc_host_line
